/* File: guard_defines.svh */
// register offsets, field positions, reset values and fixed address maps of the mode access guard
`ifndef GUARD_DEFINES_SVH
`define GUARD_DEFINES_SVH

// ----------------------------------------------------------------
// sfr address map
// ----------------------------------------------------------------
`define SFR_GENCPU_LO    8'h80
`define SFR_GENCPU_HI    8'h9F
`define SFR_SEGBASE_LO   8'hA0
`define SFR_SEGBASE_HI   8'hA1
`define SFR_XCH_CTRL     8'hA2
`define SFR_MMUCFG_LO    8'hA0
`define SFR_MMUCFG_HI    8'hA7
`define SFR_SYSMGT_LO    8'hB0
`define SFR_SYSMGT_HI    8'hBF
`define SFR_PSH          8'hB0
`define SFR_HWCOMP_LO    8'hC0
`define SFR_HWCOMP_HI    8'hFF

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define PSH_MODE_LSB     0
`define PSH_MODE_MSB     2
`define XCH_EN_BIT       0
`define PSH_RST          8'h00
`define SEGBASE_RST      16'h0000
`define XCH_CTRL_RST     8'h00
`define SFR_READ_DENIED  8'h00

// ----------------------------------------------------------------
// call targets that change mode
// ----------------------------------------------------------------
`define SYS_VEC_ADDR     16'h0800
`define CFG_VEC_ADDR     16'h0810
`define SPC_CALL_LO      16'h0900
`define SPC_CALL_HI      16'h09FF

// ----------------------------------------------------------------
// fixed memory partition, contactless part starts at the three bases, exchange ram lies below the ram base
// ----------------------------------------------------------------
`define CLOS_ROM_BASE    16'hF000
`define CLOS_EE_BASE     16'hE000
`define CLOS_RAM_BASE    16'h0F00
`define XCH_RAM_LO       16'h0E00
`define XCH_RAM_HI       16'h0E3F

`endif

/* File: guard_pkg.sv */
// types shared by the mode access guard files
package guard_pkg;

  typedef enum logic [2:0] {
    MODE_BOOT   = 3'b000,
    MODE_TEST   = 3'b001,
    MODE_CLOS   = 3'b010,
    MODE_SYSTEM = 3'b011,
    MODE_USER   = 3'b100
  } cpu_mode_e;

  typedef enum logic [1:0] {
    SPACE_ROM = 2'b00,
    SPACE_EE  = 2'b01,
    SPACE_RAM = 2'b10
  } mem_space_e;

  typedef enum logic [0:0] {
    SEQ_RUN      = 1'b0,
    SEQ_POP_WAIT = 1'b1
  } seq_state_e;

  typedef enum logic [1:0] {
    CALL_LONG = 2'b00,
    CALL_ABS  = 2'b01,
    CALL_EXT  = 2'b10
  } call_kind_e;

endpackage : guard_pkg

/* File: mode_stack_mem.sv */
// small memory holding the modes to return to on interrupt exit
`timescale 1ns/1ps
module mode_stack_mem #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 3,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_wr_en,
  input  wire logic [AW-1:0]    i_wr_addr,
  input  wire logic [WIDTH-1:0] i_wr_data,
  input  wire logic [AW-1:0]    i_rd_addr,
  output logic      [WIDTH-1:0] o_rd_data
);

  logic [WIDTH-1:0] mem_r [DEPTH];

  // refused at elaboration: the pointer wraps on a power-of-two depth only
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_chk
    $error("mode_stack_mem: DEPTH must be a power of two, at least 2");
  end

  // ----------------------------------------------------------------
  // storage, read data registered
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_wr_en) begin
      mem_r[i_wr_addr] <= i_wr_data;
    end
    o_rd_data <= mem_r[i_rd_addr];
  end

endmodule : mode_stack_mem

/* File: mem_partition_check.sv */
// fixed memory partition: which side of the split an address falls on
`timescale 1ns/1ps
module mem_partition_check
  import guard_pkg::*;
(
  input  wire logic [1:0]  i_space,
  input  wire logic [15:0] i_addr,
  output logic             o_in_clos,
  output logic             o_in_xch
);
`include "guard_defines.svh"

  // bases are constants: the split cannot be moved by any mode
  localparam logic [15:0] BASES [3] = '{`CLOS_ROM_BASE, `CLOS_EE_BASE, `CLOS_RAM_BASE};

  logic [2:0] hit;

  // ----------------------------------------------------------------
  // one comparator per memory space
  // ----------------------------------------------------------------
  for (genvar s = 0; s < 3; s++) begin : g_space
    assign hit[s] = (i_space == 2'(s)) && (i_addr >= BASES[s]);
  end

  assign o_in_clos = |hit;
  assign o_in_xch  = (i_space == SPACE_RAM) && (i_addr >= `XCH_RAM_LO) && (i_addr <= `XCH_RAM_HI);

endmodule : mem_partition_check

/* File: cpu_mode_access_guard.sv */
// cpu mode tracking, sfr access control and memory access control for the secure core
// Contract
// - system mode may rewrite the segment table base and write the table in writable memory.
// - user mode never reaches the mmu configuration registers.
// - the segment table gets no special protection; normal segment rights apply.
// - contactless os code is isolated from system and user code by fixed partition.
// - the shared exchange ram area is enabled only by system mode code.
// - reset clears segment table base to zero, disabling all user segments.
// - no mode can reconfigure the memory partition; it is fixed in hardware.
// - no subject can replace the restrictive reset defaults.
// - security registers are written only from a mode with write permission.
// - calling the system or configuration vector switches the cpu mode; the guard does this only from user or system mode, into system mode.
// - exception or interrupt entry switches the cpu mode.
// - return from interrupt switches the cpu mode back.
// - long, absolute or extended call to a special address switches the mode; the guard does this only from system mode, into user mode.
// - permitted writes to the mode bits of the status high register switch mode; from system mode the guard switches only to user or system mode.
// - refused reads return zero; refused writes leave the register unchanged.
// - mmu configuration registers are refused outside system mode.
`timescale 1ns/1ps
module cpu_mode_access_guard
  import guard_pkg::*;
#(
  parameter int STACK_DEPTH = 8
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  // sfr access from the core
  input  wire logic        i_sfr_rd,
  input  wire logic        i_sfr_wr,
  input  wire logic [7:0]  i_sfr_addr,
  input  wire logic [7:0]  i_sfr_wdata,
  input  wire logic [7:0]  i_sfr_ext_rdata,
  input  wire logic        i_hw_sfr_perm,
  // memory access from the core
  input  wire logic        i_mem_req,
  input  wire logic        i_mem_wr,
  input  wire logic [1:0]  i_mem_space,
  input  wire logic [15:0] i_mem_addr,
  input  wire logic        i_seg_perm_rd,
  input  wire logic        i_seg_perm_wr,
  // mode change events
  input  wire logic        i_call_valid,
  input  wire logic [1:0]  i_call_kind,
  input  wire logic [15:0] i_call_target,
  input  wire logic        i_exc_entry,
  input  wire logic        i_return_from_interrupt,
  input  wire logic        i_boot_exit,
  input  wire logic        i_test_entry,
  // answers
  output logic [7:0]       o_sfr_rdata,
  output logic             o_sfr_rvalid,
  output logic             o_sfr_ext_wr,
  output logic [7:0]       o_sfr_ext_addr,
  output logic [7:0]       o_sfr_ext_wdata,
  output logic             o_sfr_denied,
  output logic             o_mem_grant,
  output logic             o_mem_deny,
  output logic [2:0]       o_cpu_mode,
  output logic [15:0]      o_seg_table_base,
  output logic             o_xch_en,
  output logic             o_mode_changed,
  output logic             o_busy
);
`include "guard_defines.svh"

  localparam int AW = $clog2(STACK_DEPTH);

  // refused at elaboration, before any logic is built
  if (STACK_DEPTH < 2 || STACK_DEPTH > 256) begin : g_depth_chk
    $error("cpu_mode_access_guard: STACK_DEPTH out of range");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  cpu_mode_e   mode_r, mode_nxt;
  seq_state_e  seq_r, seq_nxt;
  logic [15:0] seg_base_r;
  logic [7:0]  xch_ctrl_r;
  logic [AW:0] sp_r, sp_nxt;
  logic [2:0]  pop_data;

  // ----------------------------------------------------------------
  // sfr decode
  // ----------------------------------------------------------------
  wire in_gencpu = (i_sfr_addr >= `SFR_GENCPU_LO) && (i_sfr_addr <= `SFR_GENCPU_HI);
  wire in_mmucfg = (i_sfr_addr >= `SFR_MMUCFG_LO) && (i_sfr_addr <= `SFR_MMUCFG_HI);
  wire in_sysmgt = (i_sfr_addr >= `SFR_SYSMGT_LO) && (i_sfr_addr <= `SFR_SYSMGT_HI);
  wire in_hwcomp = (i_sfr_addr >= `SFR_HWCOMP_LO) && (i_sfr_addr <= `SFR_HWCOMP_HI);
  wire is_psh    = (i_sfr_addr == `SFR_PSH);

  wire priv_mode = (mode_r == MODE_BOOT) || (mode_r == MODE_TEST);
  wire sys_mode  = (mode_r == MODE_SYSTEM);
  wire usr_mode  = (mode_r == MODE_USER);
  wire clos_mode = (mode_r == MODE_CLOS);

  // the mmu group is closed to every mode but system
  wire mmu_ok    = sys_mode;
  wire sysmgt_ok = priv_mode || sys_mode;
  wire hw_ok     = priv_mode || sys_mode || ((usr_mode || clos_mode) && i_hw_sfr_perm);

  wire rd_allow = in_gencpu
               || (in_mmucfg && mmu_ok)
               || (in_sysmgt && (sysmgt_ok || (is_psh && (usr_mode || clos_mode))))
               || (in_hwcomp && hw_ok);
  wire wr_allow = in_gencpu
               || (in_mmucfg && mmu_ok)
               || (in_sysmgt && sysmgt_ok)
               || (in_hwcomp && hw_ok);

  wire sfr_wr_ok = i_sfr_wr && wr_allow && (seq_r == SEQ_RUN);
  wire sfr_rd_ok = i_sfr_rd && rd_allow;

  wire wr_segbase_lo = sfr_wr_ok && (i_sfr_addr == `SFR_SEGBASE_LO);
  wire wr_segbase_hi = sfr_wr_ok && (i_sfr_addr == `SFR_SEGBASE_HI);
  wire wr_xch        = sfr_wr_ok && (i_sfr_addr == `SFR_XCH_CTRL);
  wire wr_psh        = sfr_wr_ok && is_psh;
  wire internal_reg  = in_mmucfg || is_psh;

  wire [7:0] psh_view = {5'h00, mode_r};
  wire [7:0] int_rdata = (i_sfr_addr == `SFR_SEGBASE_LO) ? seg_base_r[7:0]  :
                         (i_sfr_addr == `SFR_SEGBASE_HI) ? seg_base_r[15:8] :
                         (i_sfr_addr == `SFR_XCH_CTRL)   ? xch_ctrl_r       :
                         is_psh                          ? psh_view         : 8'h00;
  wire [7:0] rdata_nxt = !sfr_rd_ok  ? `SFR_READ_DENIED :
                         internal_reg ? int_rdata : i_sfr_ext_rdata;

  // ----------------------------------------------------------------
  // mode bit write legality
  // ----------------------------------------------------------------
  wire [2:0] psh_mode_req = i_sfr_wdata[`PSH_MODE_MSB:`PSH_MODE_LSB];
  wire psh_target_ok = priv_mode
                    || (sys_mode && ((psh_mode_req == MODE_USER) || (psh_mode_req == MODE_SYSTEM)));
  wire psh_mode_wr   = wr_psh && psh_target_ok;

  // ----------------------------------------------------------------
  // call targets
  // ----------------------------------------------------------------
  wire call_kind_ok = (i_call_kind == CALL_LONG) || (i_call_kind == CALL_ABS) || (i_call_kind == CALL_EXT);
  wire vec_call     = i_call_valid && ((i_call_target == `SYS_VEC_ADDR) || (i_call_target == `CFG_VEC_ADDR));
  wire spc_call     = i_call_valid && call_kind_ok && sys_mode
                   && (i_call_target >= `SPC_CALL_LO) && (i_call_target <= `SPC_CALL_HI);

  // ----------------------------------------------------------------
  // mode sequencer
  // ----------------------------------------------------------------
  wire stack_full  = (sp_r == (AW+1)'(STACK_DEPTH));
  wire stack_empty = (sp_r == '0);
  logic push;

  always_comb begin
    mode_nxt = mode_r;
    seq_nxt  = seq_r;
    sp_nxt   = sp_r;
    push     = 1'b0;
    case (seq_r)
      SEQ_RUN: begin
        if (i_exc_entry) begin
          mode_nxt = MODE_SYSTEM;
          push     = !stack_full;
        end else if (i_return_from_interrupt) begin
          if (!stack_empty) begin
            sp_nxt  = sp_r - (AW+1)'(1);
            seq_nxt = SEQ_POP_WAIT;
          end
        end else if (vec_call && (usr_mode || sys_mode)) begin
          mode_nxt = MODE_SYSTEM;
          push     = !stack_full;
        end else if (spc_call) begin
          mode_nxt = MODE_USER;
        end else if (psh_mode_wr) begin
          mode_nxt = cpu_mode_e'(psh_mode_req);
        end else if (i_test_entry && (mode_r == MODE_BOOT)) begin
          mode_nxt = MODE_TEST;
        end else if (i_boot_exit && priv_mode) begin
          mode_nxt = MODE_SYSTEM;
        end
        if (push) begin
          sp_nxt = sp_r + (AW+1)'(1);
        end
      end
      SEQ_POP_WAIT: begin
        mode_nxt = cpu_mode_e'(pop_data);
        seq_nxt  = SEQ_RUN;
      end
      default: begin
        seq_nxt = SEQ_RUN;
      end
    endcase
  end

  // the stack read address follows the pointer, so one cycle after return_from_interrupt the
  // popped entry is on the registered read port
  mode_stack_mem #(
    .DEPTH (STACK_DEPTH),
    .WIDTH (3),
    .AW    (AW)
  ) u_stack (
    .i_core_clk (i_core_clk),
    .i_wr_en    (push),
    .i_wr_addr  (sp_r[AW-1:0]),
    .i_wr_data  (mode_r),
    .i_rd_addr  (sp_nxt[AW-1:0]),
    .o_rd_data  (pop_data)
  );

  // ----------------------------------------------------------------
  // memory access check
  // ----------------------------------------------------------------
  logic in_clos;
  logic in_xch;

  mem_partition_check u_part (
    .i_space   (i_mem_space),
    .i_addr    (i_mem_addr),
    .o_in_clos (in_clos),
    .o_in_xch  (in_xch)
  );

  wire seg_enabled = (seg_base_r != `SEGBASE_RST);
  // table writes go through the same segment rights as any other data
  wire usr_mem_ok  = seg_enabled && (i_mem_wr ? i_seg_perm_wr : i_seg_perm_rd);
  wire app_side    = !in_clos;
  wire mem_ok = (mode_r == MODE_TEST)
             || ((mode_r == MODE_BOOT) && in_clos)
             || (clos_mode && (in_clos || (in_xch && xch_ctrl_r[`XCH_EN_BIT])))
             || (sys_mode && app_side)
             || (usr_mode && app_side && usr_mem_ok);

  // ----------------------------------------------------------------
  // registers; reset values are constants that no input can alter
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_r     <= cpu_mode_e'(3'(`PSH_RST));
      seq_r      <= SEQ_RUN;
      sp_r       <= '0;
      seg_base_r <= `SEGBASE_RST;
      xch_ctrl_r <= `XCH_CTRL_RST;
    end else begin
      mode_r <= mode_nxt;
      seq_r  <= seq_nxt;
      sp_r   <= sp_nxt;
      if (wr_segbase_lo) begin
        seg_base_r[7:0] <= i_sfr_wdata;
      end
      if (wr_segbase_hi) begin
        seg_base_r[15:8] <= i_sfr_wdata;
      end
      if (wr_xch) begin
        xch_ctrl_r <= i_sfr_wdata;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sfr_rdata  <= 8'h00;
      o_sfr_rvalid <= 1'b0;
      o_sfr_denied <= 1'b0;
    end else begin
      o_sfr_rdata  <= i_sfr_rd ? rdata_nxt : 8'h00;
      o_sfr_rvalid <= i_sfr_rd;
      o_sfr_denied <= (i_sfr_rd && !rd_allow) || (i_sfr_wr && !sfr_wr_ok);
    end
  end

  // refused writes never reach the outside registers
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sfr_ext_wr    <= 1'b0;
      o_sfr_ext_addr  <= 8'h00;
      o_sfr_ext_wdata <= 8'h00;
    end else begin
      o_sfr_ext_wr    <= sfr_wr_ok && !internal_reg;
      o_sfr_ext_addr  <= i_sfr_addr;
      o_sfr_ext_wdata <= i_sfr_wdata;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_mem_grant <= 1'b0;
      o_mem_deny  <= 1'b0;
    end else begin
      o_mem_grant <= i_mem_req && mem_ok;
      o_mem_deny  <= i_mem_req && !mem_ok;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cpu_mode       <= 3'(`PSH_RST);
      o_seg_table_base <= `SEGBASE_RST;
      o_xch_en         <= 1'b0;
      o_mode_changed   <= 1'b0;
      o_busy           <= 1'b0;
    end else begin
      o_cpu_mode       <= mode_nxt;
      o_seg_table_base <= seg_base_r;
      o_xch_en         <= xch_ctrl_r[`XCH_EN_BIT];
      o_mode_changed   <= (mode_nxt != mode_r);
      o_busy           <= (seq_nxt == SEQ_POP_WAIT);
    end
  end

endmodule : cpu_mode_access_guard

/* File: ext_sfr_model.sv */
// outside sfr file behind the guard's external register port
`timescale 1ns/1ps
module ext_sfr_model (
  input  wire logic       i_core_clk,
  input  wire logic       i_wr,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic [7:0] i_rd_addr,
  output logic      [7:0] o_rdata
);
  logic [7:0] regs_r [256];
  // distinct start values, so a zero or stale answer never passes by chance
  initial for (int n = 0; n < 256; n++) regs_r[n] = 8'(n) ^ 8'hA5;
  always @(posedge i_core_clk) if (i_wr) regs_r[i_addr] <= i_wdata;
  assign o_rdata = regs_r[i_rd_addr];
endmodule : ext_sfr_model

/* File: cpu_mode_access_guard_sva.sv */
// port assertions of the mode access guard
`timescale 1ns/1ps
`include "guard_defines.svh"
module cpu_mode_access_guard_chk
  import guard_pkg::*;
#(
  parameter int STACK_DEPTH = 8
) (
  input wire logic        i_core_clk,
  input wire logic        i_rst_n,
  input wire logic        i_sfr_rd,
  input wire logic        i_sfr_wr,
  input wire logic [7:0]  i_sfr_addr,
  input wire logic        i_mem_req,
  input wire logic        i_call_valid,
  input wire logic [15:0] i_call_target,
  input wire logic        i_exc_entry,
  input wire logic        i_return_from_interrupt,
  input wire logic [7:0]  o_sfr_rdata,
  input wire logic        o_sfr_rvalid,
  input wire logic        o_sfr_ext_wr,
  input wire logic        o_sfr_denied,
  input wire logic        o_mem_deny,
  input wire logic [2:0]  o_cpu_mode,
  input wire logic [15:0] o_seg_table_base,
  input wire logic        o_mode_changed,
  input wire logic        o_busy
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  wire logic cfg_hit = i_sfr_addr >= `SFR_MMUCFG_LO && i_sfr_addr <= `SFR_MMUCFG_HI;
  wire logic quiet   = !o_busy && !i_exc_entry && !i_return_from_interrupt;
  wire logic vec_hit = i_call_valid && (i_call_target == `SYS_VEC_ADDR || i_call_target == `CFG_VEC_ADDR);
  wire logic spc_hit = i_call_valid && i_call_target >= `SPC_CALL_LO && i_call_target <= `SPC_CALL_HI;
  a_rd_answer: assert property (i_sfr_rd |=> o_sfr_rvalid) else $error("read not answered");
  a_refused_zero: assert property (o_sfr_rvalid && o_sfr_denied |-> o_sfr_rdata == `SFR_READ_DENIED)
    else $error("refused read leaked data");
  a_cfg_system_only: assert property ((i_sfr_rd || i_sfr_wr) && cfg_hit && o_cpu_mode != MODE_SYSTEM
    |=> o_sfr_denied && !o_sfr_ext_wr) else $error("mmu config reached outside system mode");
  a_base_from_system: assert property ($changed(o_seg_table_base)
    |-> $past(i_sfr_wr, 2) && $past(o_cpu_mode, 2) == MODE_SYSTEM) else $error("table base changed wrongly");
  a_exc_to_system: assert property (i_exc_entry && !o_busy |=> o_cpu_mode == MODE_SYSTEM)
    else $error("exception entry kept mode");
  a_return_from_interrupt_pop: assert property ($rose(o_busy) |-> $past(i_return_from_interrupt) ##1 !o_busy)
    else $error("return pop cycle wrong");
  a_vector_call: assert property (vec_hit && quiet && (o_cpu_mode == MODE_USER || o_cpu_mode == MODE_SYSTEM)
    |=> o_cpu_mode == MODE_SYSTEM) else $error("vector call kept mode");
  a_special_call: assert property (spc_hit && quiet && o_cpu_mode == MODE_SYSTEM |=> o_cpu_mode == MODE_USER)
    else $error("special call kept mode");
  a_change_flag: assert property (o_mode_changed == (o_cpu_mode != $past(o_cpu_mode)))
    else $error("mode change pulse wrong");
  a_user_base_zero: assert property (i_mem_req && o_cpu_mode == MODE_USER && o_seg_table_base == `SEGBASE_RST
    |=> o_mem_deny) else $error("user access with empty table");
endmodule : cpu_mode_access_guard_chk

bind cpu_mode_access_guard cpu_mode_access_guard_chk #(.STACK_DEPTH(STACK_DEPTH)) chk_inst (
  .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_sfr_rd(i_sfr_rd), .i_sfr_wr(i_sfr_wr),
  .i_sfr_addr(i_sfr_addr), .i_mem_req(i_mem_req), .i_call_valid(i_call_valid),
  .i_call_target(i_call_target), .i_exc_entry(i_exc_entry), .i_return_from_interrupt(i_return_from_interrupt), .o_sfr_rdata(o_sfr_rdata),
  .o_sfr_rvalid(o_sfr_rvalid), .o_sfr_ext_wr(o_sfr_ext_wr), .o_sfr_denied(o_sfr_denied),
  .o_mem_deny(o_mem_deny), .o_cpu_mode(o_cpu_mode), .o_seg_table_base(o_seg_table_base),
  .o_mode_changed(o_mode_changed), .o_busy(o_busy));

/* File: test_cpu_mode_access_guard.sv */
// self-checking bench of the mode access guard
`timescale 1ns/1ps
`include "guard_defines.svh"
module test_cpu_mode_access_guard
  import guard_pkg::*;
;
  logic        i_core_clk = 0, i_rst_n = 0, i_sfr_rd = 0, i_sfr_wr = 0, i_hw_sfr_perm = 0;
  logic [7:0]  i_sfr_addr = 0, i_sfr_wdata = 0, i_sfr_ext_rdata;
  logic        i_mem_req = 0, i_mem_wr = 0, i_seg_perm_rd = 0, i_seg_perm_wr = 0, i_call_valid = 0;
  logic [1:0]  i_mem_space = 0, i_call_kind = 0;
  logic [15:0] i_mem_addr = 0, i_call_target = 0, o_seg_table_base;
  logic        i_exc_entry = 0, i_return_from_interrupt = 0, i_boot_exit = 0, i_test_entry = 0;
  logic [7:0]  o_sfr_rdata, o_sfr_ext_addr, o_sfr_ext_wdata;
  logic        o_sfr_rvalid, o_sfr_ext_wr, o_sfr_denied, o_mem_grant, o_mem_deny, o_xch_en, o_mode_changed, o_busy;
  logic [2:0]  o_cpu_mode;
  int          failures = 0, checked = 0;

  always #20 i_core_clk = ~i_core_clk;

  cpu_mode_access_guard #(.STACK_DEPTH(8)) cpu_mode_access_guard_inst (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_sfr_rd(i_sfr_rd), .i_sfr_wr(i_sfr_wr),
    .i_sfr_addr(i_sfr_addr), .i_sfr_wdata(i_sfr_wdata), .i_sfr_ext_rdata(i_sfr_ext_rdata),
    .i_hw_sfr_perm(i_hw_sfr_perm), .i_mem_req(i_mem_req), .i_mem_wr(i_mem_wr), .i_mem_space(i_mem_space),
    .i_mem_addr(i_mem_addr), .i_seg_perm_rd(i_seg_perm_rd), .i_seg_perm_wr(i_seg_perm_wr),
    .i_call_valid(i_call_valid), .i_call_kind(i_call_kind), .i_call_target(i_call_target),
    .i_exc_entry(i_exc_entry), .i_return_from_interrupt(i_return_from_interrupt), .i_boot_exit(i_boot_exit), .i_test_entry(i_test_entry),
    .o_sfr_rdata(o_sfr_rdata), .o_sfr_rvalid(o_sfr_rvalid), .o_sfr_ext_wr(o_sfr_ext_wr),
    .o_sfr_ext_addr(o_sfr_ext_addr), .o_sfr_ext_wdata(o_sfr_ext_wdata), .o_sfr_denied(o_sfr_denied),
    .o_mem_grant(o_mem_grant), .o_mem_deny(o_mem_deny), .o_cpu_mode(o_cpu_mode),
    .o_seg_table_base(o_seg_table_base), .o_xch_en(o_xch_en), .o_mode_changed(o_mode_changed), .o_busy(o_busy));

  ext_sfr_model ext_sfr_model_inst (
    .i_core_clk(i_core_clk), .i_wr(o_sfr_ext_wr), .i_addr(o_sfr_ext_addr), .i_wdata(o_sfr_ext_wdata),
    .i_rd_addr(i_sfr_addr), .o_rdata(i_sfr_ext_rdata));

  // ----------------------------------------------------------------
  // shared drivers and comparison
  // ----------------------------------------------------------------
  task automatic stop_test();
    if (failures == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // k: 0 exception, 1 return, 2 call, 3 boot exit, 4 test entry
  task automatic ev(input int k, input logic [15:0] tgt, input logic [1:0] kind, input logic [2:0] exp);
    logic [2:0] prev;
    @(negedge i_core_clk);
    prev = o_cpu_mode;
    {i_exc_entry, i_return_from_interrupt, i_call_valid, i_boot_exit, i_test_entry} = {k == 0, k == 1, k == 2, k == 3, k == 4};
    i_call_target = tgt;
    i_call_kind = kind;
    @(negedge i_core_clk);
    {i_exc_entry, i_return_from_interrupt, i_call_valid, i_boot_exit, i_test_entry} = '0;
    if (k == 1) begin
      chk("busy", 1, o_busy);
      @(negedge i_core_clk);
    end
    chk("mode", exp, o_cpu_mode);
    chk("mode changed", exp != prev, o_mode_changed);
  endtask : ev

  task automatic sfr(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic den, input logic [7:0] rd);
    @(negedge i_core_clk);
    i_sfr_wr = wr;
    i_sfr_rd = !wr;
    i_sfr_addr = a;
    i_sfr_wdata = d;
    @(negedge i_core_clk);
    i_sfr_wr = 0;
    i_sfr_rd = 0;
    chk("sfr denied", den, o_sfr_denied);
    chk("read valid", !wr, o_sfr_rvalid);
    // the mmu group and the status high register stay inside, the rest goes out
    if (wr) chk("ext write", !den && (a < `SFR_MMUCFG_LO || a > `SFR_MMUCFG_HI) && a != `SFR_PSH, o_sfr_ext_wr);
    else chk("read data", rd, o_sfr_rdata);
  endtask : sfr

  task automatic mem(input logic [1:0] sp, input logic [15:0] a, input logic perm, input logic gr);
    @(negedge i_core_clk);
    {i_mem_req, i_mem_wr, i_seg_perm_rd, i_seg_perm_wr} = {1'b1, perm, perm, perm};
    i_mem_space = sp;
    i_mem_addr = a;
    @(negedge i_core_clk);
    i_mem_req = 0;
    chk("grant", gr, o_mem_grant);
    chk("deny", !gr, o_mem_deny);
  endtask : mem

  task automatic t_system();
    mem(SPACE_RAM, `CLOS_RAM_BASE, 1, 1);
    mem(SPACE_ROM, 16'h0100, 0, 0);
    ev(3, 0, 0, MODE_SYSTEM);
    sfr(1, `SFR_SEGBASE_LO, 8'h34, 0, 0);
    sfr(1, `SFR_SEGBASE_HI, 8'h12, 0, 0);
    sfr(0, `SFR_SEGBASE_LO, 0, 0, 8'h34);
    chk("seg base", 16'h1234, o_seg_table_base);
    sfr(1, `SFR_XCH_CTRL, 8'h01, 0, 0);
    @(negedge i_core_clk);
    chk("xch enable", 1, o_xch_en);
    mem(SPACE_ROM, 16'h0100, 0, 1);
    mem(SPACE_ROM, `CLOS_ROM_BASE, 0, 0);
    for (int k = 0; k < 3; k++) begin
      ev(2, `SPC_CALL_LO + 16'(k), 2'(k), MODE_USER);
      ev(2, k[0] ? `CFG_VEC_ADDR : `SYS_VEC_ADDR, 0, MODE_SYSTEM);
    end
  endtask : t_system

  task automatic t_user();
    ev(2, `SPC_CALL_HI, CALL_EXT, MODE_USER);
    sfr(1, `SFR_SEGBASE_LO, 8'h55, 1, 0);
    sfr(0, `SFR_SEGBASE_HI, 0, 1, 0);
    sfr(1, `SFR_XCH_CTRL, 8'h00, 1, 0);
    sfr(1, `SFR_PSH, 8'h03, 1, 0);
    chk("seg base", 16'h1234, o_seg_table_base);
    chk("xch enable", 1, o_xch_en);
    chk("mode", MODE_USER, o_cpu_mode);
    sfr(1, 8'h85, 8'h6C, 0, 0);
    sfr(0, 8'h85, 0, 0, 8'h6C);
    sfr(0, `SFR_HWCOMP_LO, 0, 1, 0);
    i_hw_sfr_perm = 1;
    sfr(1, `SFR_HWCOMP_LO, 8'h3C, 0, 0);
    i_hw_sfr_perm = 0;
    mem(SPACE_RAM, 16'h0200, 1, 1);
    mem(SPACE_RAM, 16'h0200, 0, 0);
    ev(0, 0, 0, MODE_SYSTEM);
    ev(1, 0, 0, MODE_USER);
    ev(2, `SYS_VEC_ADDR, 0, MODE_SYSTEM);
    sfr(1, `SFR_PSH, 8'(MODE_USER), 0, 0);
    @(negedge i_core_clk);
    chk("mode", MODE_USER, o_cpu_mode);
  endtask : t_user

  task automatic t_reset();
    i_rst_n = 0;
    repeat (3) @(negedge i_core_clk);
    chk("seg base", `SEGBASE_RST, o_seg_table_base);
    chk("mode", MODE_BOOT, o_cpu_mode);
    chk("xch enable", 0, o_xch_en);
    i_rst_n = 1;
    ev(4, 0, 0, MODE_TEST);
    mem(SPACE_ROM, 16'h0100, 0, 1);
    sfr(1, `SFR_PSH, 8'(MODE_CLOS), 0, 0);
    sfr(0, `SFR_PSH, 0, 0, 8'(MODE_CLOS));
    mem(SPACE_EE, `CLOS_EE_BASE, 0, 1);
    mem(SPACE_RAM, 16'h0200, 0, 0);
    mem(SPACE_RAM, `XCH_RAM_LO, 0, 0);
    sfr(1, `SFR_XCH_CTRL, 8'h01, 1, 0);
    ev(0, 0, 0, MODE_SYSTEM);
    sfr(1, `SFR_XCH_CTRL, 8'h01, 0, 0);
    ev(1, 0, 0, MODE_CLOS);
    mem(SPACE_RAM, `XCH_RAM_HI, 0, 1);
    ev(0, 0, 0, MODE_SYSTEM);
    ev(2, `SPC_CALL_LO, CALL_LONG, MODE_USER);
    // an empty table must lock user code out even with segment rights granted
    mem(SPACE_RAM, 16'h0200, 1, 0);
  endtask : t_reset

  initial begin
    repeat (10) @(negedge i_core_clk);
    i_rst_n = 1;
    t_system();
    t_user();
    t_reset();
    stop_test();
  end

  // cuts a hang short; the whole run needs well under a thousand cycles
  initial begin
    #2000000;
    failures++;
    stop_test();
  end
endmodule : test_cpu_mode_access_guard
